// [bench/ips_pending_checker.sv]
// Checker: port-level assertions for the pending block
`timescale 1ns/1ps
module ips_pending_checker
    import ips_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] addr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic ext_request_lvl_five_i,
    input wire logic ext_request_lvl_six_i,
    input wire logic ext_request_lvl_three_i,
    input wire logic ext_request_lvl_two_i,
    input wire logic ext_request_lvl_one_i,
    input wire logic [3:0] key_input_irq_i,
    input wire logic [31:0] interrupt_pending_o,
    input wire logic [2:0] irq_level_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////
    // Latch and output register take two cycles in either mode; window allows two or three
    sequence s_req_rise(logic req);
        $rose(req);
    endsequence
    property p_rise_sets(logic req, logic pend);
        s_req_rise(req) |-> ##[2:3] pend;
    endproperty
    sequence s_pend_read;
        rd_i && addr_i == IPS_ADDR_PENDING ##1 1'b1;
    endsequence
    a_five_follows: assert property (
        interrupt_pending_o[20] == $past(ext_request_lvl_five_i, 2))
        else $error("level five lag");
    a_six_sets: assert property (
        p_rise_sets(ext_request_lvl_six_i, interrupt_pending_o[19]))
        else $error("level six miss");
    a_three_sets: assert property (
        p_rise_sets(ext_request_lvl_three_i, interrupt_pending_o[18]))
        else $error("level three miss");
    a_two_sets: assert property (
        p_rise_sets(ext_request_lvl_two_i, interrupt_pending_o[17]))
        else $error("level two miss");
    a_one_sets: assert property (
        p_rise_sets(ext_request_lvl_one_i, interrupt_pending_o[16]))
        else $error("level one miss");
    a_key_sets: assert property (
        p_rise_sets(key_input_irq_i[3], interrupt_pending_o[11]))
        else $error("key miss");
    a_reserved_zero: assert property (
        {interrupt_pending_o[31:21], interrupt_pending_o[15:14]} == 13'h0)
        else $error("reserved bit set");
    a_read_match: assert property (
        s_pend_read |-> rdata_o == interrupt_pending_o)
        else $error("read differs");
    a_level_legal: assert property (
        irq_level_o != IPS_LVL_BAD)
        else $error("bad level");
    a_level_cause: assert property (
        irq_level_o != IPS_LVL_NONE |-> interrupt_pending_o != IPS_ZERO
        || $past(interrupt_pending_o) != IPS_ZERO)
        else $error("level without pending");
endmodule : ips_pending_checker

bind ips_pending ips_pending_checker i_ips_pending_checker (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .ext_request_lvl_five_i(ext_request_lvl_five_i),
    .ext_request_lvl_six_i(ext_request_lvl_six_i),
    .ext_request_lvl_three_i(ext_request_lvl_three_i),
    .ext_request_lvl_two_i(ext_request_lvl_two_i),
    .ext_request_lvl_one_i(ext_request_lvl_one_i),
    .key_input_irq_i(key_input_irq_i),
    .interrupt_pending_o(interrupt_pending_o), .irq_level_o(irq_level_o));

// [bench/ips_pending_tb_top.sv]
// Testbench: register and source scenarios for the pending block
`timescale 1ns/1ps
module ips_pending_tb_top;
    import ips_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] cmd = 32'h0;
    logic [31:0] req;
    logic [31:0] rdata_o;
    logic [31:0] pend;
    logic [2:0] lvl;
    logic [31:0] e;
    int miscompares = 0;
    int check_count = 0;
    ips_source_model i_ips_source_model (.cmd_i(cmd), .req_o(req));
    ips_pending i_ips_pending (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .ext_request_lvl_five_i(req[20]),
        .ext_request_lvl_six_i(req[19]), .ext_request_lvl_three_i(req[18]),
        .ext_request_lvl_two_i(req[17]), .ext_request_lvl_one_i(req[16]),
        .pulse_mod_b_irq_i(req[13]), .serial_port_b_irq_i(req[12]),
        .key_input_irq_i(req[11:8]), .pulse_mod_a_irq_i(req[7]),
        .keypad_irq_i(req[6]), .gp_counter_b_irq_i(req[5]),
        .rtc_irq_i(req[4]), .watchdog_irq_i(req[3]),
        .serial_port_a_irq_i(req[2]), .gp_counter_a_irq_i(req[1]),
        .sync_serial_b_irq_i(req[0]), .interrupt_pending_o(pend),
        .irq_level_o(lvl));
    ////////////////////////////////////////
    initial
    begin
        forever #12.5 mclk_i = ~mclk_i;
    end
    task automatic chk(input string nm, input logic [31:0] got,
        input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask : reg_wr
    task automatic rchk(input string nm, input logic [3:0] a,
        input logic [31:0] exp);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 chk(nm, rdata_o, exp);
    endtask : rchk
    // Request settles through two stages, so four cycles leave margin
    task automatic src(input logic [31:0] v);
        @(posedge mclk_i);
        cmd <= v;
        repeat (4) @(posedge mclk_i);
        #1;
    endtask : src
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict
    initial
    begin
        repeat (10) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        rchk("mask", IPS_ADDR_MASK, IPS_MASK_RESET);
        rchk("level", IPS_ADDR_LEVEL, {16'h0, IPS_LEVEL_RESET});
        rchk("unmapped", 4'hF, IPS_ZERO);
        for (int b = 0; b < 21; b++)
        begin
            e = 32'h1 << b;
            if ((e & IPS_PEND_MASK) != 32'h0)
            begin
                src(e);
                rchk("pend", IPS_ADDR_PENDING, e);
                rchk("status", IPS_ADDR_STATUS, IPS_ZERO);
                src(IPS_ZERO);
                rchk("pend", IPS_ADDR_PENDING, IPS_ZERO);
            end
        end
        reg_wr(IPS_ADDR_MASK, IPS_ZERO);
        src(32'h0000_2080);
        rchk("status", IPS_ADDR_STATUS, 32'h0000_2080);
        chk("top", {29'h0, lvl}, 32'h6);
        // Field of code seven must be ignored
        reg_wr(IPS_ADDR_LEVEL, 32'h0000_6713);
        rchk("level", IPS_ADDR_LEVEL, 32'h0000_6313);
        src(32'h0000_2000);
        rchk("prio", IPS_ADDR_PRIO, 32'h1);
        src(IPS_ZERO);
        chk("top", {29'h0, lvl}, 32'h0);
        src(32'h0000_0020);
        chk("top", {29'h0, lvl}, 32'h4);
        src(IPS_ZERO);
        reg_wr(IPS_ADDR_EDGE, 32'h0000_00FF);
        src(32'h000F_0F00);
        rchk("pend", IPS_ADDR_PENDING, 32'h000F_0F00);
        reg_wr(IPS_ADDR_PENDING, IPS_ZERO);
        rchk("pend", IPS_ADDR_PENDING, 32'h000F_0F00);
        reg_wr(IPS_ADDR_PENDING, 32'hFFFF_FFFF);
        rchk("pend", IPS_ADDR_PENDING, 32'h0000_0F00);
        reg_wr(IPS_ADDR_KEYCLR, 32'h0000_0005);
        src(IPS_ZERO);
        rchk("pend", IPS_ADDR_PENDING, 32'h0000_0A00);
        reg_wr(IPS_ADDR_KEYCLR, 32'h0000_000F);
        rchk("pend", IPS_ADDR_PENDING, IPS_ZERO);
        give_verdict();
    end
    initial
    begin
        #(25 * 3000);
        miscompares++;
        give_verdict();
    end
endmodule : ips_pending_tb_top

// [bench/ips_source_model.sv]
// Partner: peripheral units and request pins feeding the pending block
`timescale 1ns/1ps
module ips_source_model
    import ips_pkg::*;
(
    input wire logic [31:0] cmd_i,
    output logic [31:0] req_o
);
    ////////////////////////////////////////
    // Sources hold a request until removed, never self-clear
    // Reserved positions never driven
    assign req_o = cmd_i & IPS_PEND_MASK;
endmodule : ips_source_model

// [hdl/ips_latch_bit.sv]
// One pending bit: level follower or edge latch with write-one clear
`timescale 1ns/1ps
module ips_latch_bit (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic req_i,
    input wire logic edge_mode_i,
    input wire logic clr_i,
    output logic pend_o
);
    logic prev_q;
    logic pend_q;

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            prev_q <= 1'b0;
        else
            prev_q <= req_i;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            pend_q <= 1'b0;
        else if (!edge_mode_i)
            pend_q <= req_i;
        else if (req_i && !prev_q)
            pend_q <= 1'b1; // Set beats a same-cycle clear
        else if (clr_i)
            pend_q <= 1'b0;
    end

    assign pend_o = pend_q;
endmodule : ips_latch_bit

// [hdl/ips_level_map.sv]
// Priority level for each pending source
`timescale 1ns/1ps
module ips_level_map (
    input wire logic [15:0] level_ctl_i,
    input wire logic [31:0] pend_i,
    output logic [2:0] top_level_o
);
    import ips_pkg::*;

    function automatic logic [2:0] lvl_of(input int b,
                                          input logic [15:0] c);
        logic [2:0] l;
        l = IPS_LVL_NONE;
        unique case (b)
            IPS_BIT_LVL5: l = IPS_LVL_FIVE;
            IPS_BIT_LVL6, IPS_BIT_PWMA, IPS_BIT_TMRA: l = IPS_LVL_SIX;
            IPS_BIT_LVL3: l = IPS_LVL_THREE;
            IPS_BIT_LVL2: l = IPS_LVL_TWO;
            IPS_BIT_LVL1: l = IPS_LVL_ONE;
            IPS_BIT_PWMB: l = c[IPS_LVL_PWMB +: 3];
            IPS_BIT_SERB: l = c[IPS_LVL_SERB +: 3];
            IPS_BIT_TMRB: l = IPS_LVL_FOUR; // Fixed level
            IPS_BIT_SPIB: l = c[IPS_LVL_SPIB +: 3];
            IPS_BIT_KPAD, IPS_BIT_RTC, IPS_BIT_WDOG,
            IPS_BIT_SERA: l = IPS_LVL_FOUR;
            8, 9, 10, 11: l = IPS_LVL_FOUR;
            default: l = IPS_LVL_NONE;
        endcase
        // Forbidden codes never raise a request
        if (l == IPS_LVL_BAD)
            l = IPS_LVL_NONE;
        return l;
    endfunction : lvl_of

    always_comb
    begin
        top_level_o = IPS_LVL_NONE;
        for (int i = 0; i < 32; i++)
        begin
            if (pend_i[i] && lvl_of(i, level_ctl_i) > top_level_o)
                top_level_o = lvl_of(i, level_ctl_i);
        end
    end
endmodule : ips_level_map

// [hdl/ips_pending.sv]
// Interrupt pending register, bits 20..0, with mask, status and levels
//
// Behaviour
// - Bit 20 follows level-five request pin
// - Bit 19 set by level-six request pin
// - Bit 18 set by level-three request pin
// - Bit 17 set by level-two request pin
// - Bit 16 set by level-one request pin
// - Level-sensitive bits follow the source
// - Edge latched; write one clears, zero ignored
// - Bit 13 second modulator, programmable level
// - Bit 12 second serial port, programmable level
// - Four key inputs map to bits 11..8
// - Edge key bits clear via port clear only
// - Bit 7 first modulator, level six
// - Bit 6 keypad event, level four
// - Bit 5 second counter event
// - Bit 4 clock-calendar event, level four
// - Bit 3 watchdog event, level four
// - Bit 2 first serial port, level four
// - Bit 1 first counter event, level six
// - Bit 0 second synchronous serial unit
// - Pending ignores mask; status needs unmasked
`timescale 1ns/1ps
module ips_pending (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic ext_request_lvl_five_i,
    input wire logic ext_request_lvl_six_i,
    input wire logic ext_request_lvl_three_i,
    input wire logic ext_request_lvl_two_i,
    input wire logic ext_request_lvl_one_i,
    input wire logic pulse_mod_b_irq_i,
    input wire logic serial_port_b_irq_i,
    input wire logic [3:0] key_input_irq_i,
    input wire logic pulse_mod_a_irq_i,
    input wire logic keypad_irq_i,
    input wire logic gp_counter_b_irq_i,
    input wire logic rtc_irq_i,
    input wire logic watchdog_irq_i,
    input wire logic serial_port_a_irq_i,
    input wire logic gp_counter_a_irq_i,
    input wire logic sync_serial_b_irq_i,
    output logic [31:0] interrupt_pending_o,
    output logic [2:0] irq_level_o
);
    import ips_pkg::*;

    logic [31:0] pend;
    logic [31:0] mask_q;
    logic [15:0] irq_level_control_q;
    logic [7:0] edge_sel_q;
    logic [31:0] rdata_q;
    logic [31:0] pend_q;
    logic [2:0] level_q;
    logic [2:0] top_level;
    logic [3:0] ext_req;
    logic [3:0] ext_pend;
    logic [3:0] key_pend;
    logic [3:0] ext_clr;
    logic [3:0] key_clr;
    logic [15:0] periph_q;
    logic pend_wr;
    logic key_wr;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] b,
                                 input logic s);
        return s && (a == b);
    endfunction : hit

    assign pend_wr = hit(addr_i, IPS_ADDR_PENDING, wr_i);
    assign key_wr = hit(addr_i, IPS_ADDR_KEYCLR, wr_i);

    ////////////////////////////////////////////////////////////////////////
    // Edge-capable external request pins: level one, two, three, six

    assign ext_req = {ext_request_lvl_six_i, ext_request_lvl_three_i,
                      ext_request_lvl_two_i, ext_request_lvl_one_i};
    assign ext_clr = {wdata_i[IPS_BIT_LVL6], wdata_i[IPS_BIT_LVL3],
                      wdata_i[IPS_BIT_LVL2], wdata_i[IPS_BIT_LVL1]}
                     & {IPS_NUM_EXT{pend_wr}};
    // Keys ignore pending writes; only their own clear port works
    assign key_clr = wdata_i[3:0] & {IPS_NUM_KEYS{key_wr}};

    genvar g;
    generate
        for (g = 0; g < IPS_NUM_EXT; g++)
        begin : g_ext
            ips_latch_bit u_bit (
                .mclk_i(mclk_i),
                .rst_n_i(rst_n_i),
                .req_i(ext_req[g]),
                .edge_mode_i(edge_sel_q[g]),
                .clr_i(ext_clr[g]),
                .pend_o(ext_pend[g])
            );
        end
        for (g = 0; g < IPS_NUM_KEYS; g++)
        begin : g_key
            ips_latch_bit u_bit (
                .mclk_i(mclk_i),
                .rst_n_i(rst_n_i),
                .req_i(key_input_irq_i[g]),
                .edge_mode_i(edge_sel_q[IPS_EDGE_KEY0 + g]),
                .clr_i(key_clr[g]),
                .pend_o(key_pend[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Level-type peripheral sources, one register stage

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            periph_q <= 16'h0000;
        else
        begin
            periph_q[0] <= ext_request_lvl_five_i;
            periph_q[1] <= pulse_mod_b_irq_i;
            periph_q[2] <= serial_port_b_irq_i;
            periph_q[3] <= pulse_mod_a_irq_i;
            periph_q[4] <= keypad_irq_i;
            periph_q[5] <= gp_counter_b_irq_i;
            periph_q[6] <= rtc_irq_i;
            periph_q[7] <= watchdog_irq_i;
            periph_q[8] <= serial_port_a_irq_i;
            periph_q[9] <= gp_counter_a_irq_i;
            periph_q[10] <= sync_serial_b_irq_i;
            periph_q[15:11] <= 5'h00;
        end
    end

    always_comb
    begin
        pend = IPS_ZERO; // Reserved bits stay zero
        pend[IPS_BIT_LVL5] = periph_q[0];
        pend[IPS_BIT_LVL6] = ext_pend[3];
        pend[IPS_BIT_LVL3] = ext_pend[2];
        pend[IPS_BIT_LVL2] = ext_pend[1];
        pend[IPS_BIT_LVL1] = ext_pend[0];
        pend[IPS_BIT_PWMB] = periph_q[1];
        pend[IPS_BIT_SERB] = periph_q[2];
        pend[IPS_BIT_KEY0 +: IPS_NUM_KEYS] = key_pend;
        pend[IPS_BIT_PWMA] = periph_q[3];
        pend[IPS_BIT_KPAD] = periph_q[4];
        pend[IPS_BIT_TMRB] = periph_q[5];
        pend[IPS_BIT_RTC] = periph_q[6];
        pend[IPS_BIT_WDOG] = periph_q[7];
        pend[IPS_BIT_SERA] = periph_q[8];
        pend[IPS_BIT_TMRA] = periph_q[9];
        pend[IPS_BIT_SPIB] = periph_q[10];
    end

    ////////////////////////////////////////////////////////////////////////
    // Software registers

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            mask_q <= IPS_MASK_RESET;
        else if (hit(addr_i, IPS_ADDR_MASK, wr_i))
            mask_q <= wdata_i & IPS_PEND_MASK;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            edge_sel_q <= 8'h00;
        else if (hit(addr_i, IPS_ADDR_EDGE, wr_i))
            edge_sel_q <= wdata_i[7:0];
    end

    // Forbidden codes are dropped, field keeps its old level
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            irq_level_control_q <= IPS_LEVEL_RESET;
        else if (hit(addr_i, IPS_ADDR_LEVEL, wr_i))
        begin
            for (int f = 0; f < 4; f++)
            begin
                if (wdata_i[4*f +: 3] != IPS_LVL_NONE &&
                    wdata_i[4*f +: 3] != IPS_LVL_BAD)
                    irq_level_control_q[4*f +: 3] <= wdata_i[4*f +: 3];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Priority of unmasked pending sources

    ips_level_map u_map (
        .level_ctl_i(irq_level_control_q),
        .pend_i(pend & ~mask_q),
        .top_level_o(top_level)
    );

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pend_q <= IPS_ZERO;
            level_q <= IPS_LVL_NONE;
        end
        else
        begin
            pend_q <= pend;
            level_q <= top_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port, data one cycle after the strobe

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rdata_q <= IPS_ZERO;
        else if (!rd_i)
            rdata_q <= IPS_ZERO;
        else
        begin
            unique case (addr_i)
                IPS_ADDR_PENDING: rdata_q <= pend;
                IPS_ADDR_MASK: rdata_q <= mask_q;
                IPS_ADDR_STATUS: rdata_q <= pend & ~mask_q;
                IPS_ADDR_LEVEL: rdata_q <= {16'h0000, irq_level_control_q};
                IPS_ADDR_EDGE: rdata_q <= {24'h000000, edge_sel_q};
                IPS_ADDR_PRIO: rdata_q <= {29'h00000000, level_q};
                default: rdata_q <= IPS_ZERO;
            endcase
        end
    end

    assign rdata_o = rdata_q;
    assign interrupt_pending_o = pend_q;
    assign irq_level_o = level_q;
endmodule : ips_pending

// [hdl/ips_pkg.sv]
// Package: offsets, fields, reset values and codes for the pending block
package ips_pkg;
    // Register index map (plain port, word addressed)
    localparam logic [3:0] IPS_ADDR_PENDING = 4'h0;
    localparam logic [3:0] IPS_ADDR_MASK = 4'h1;
    localparam logic [3:0] IPS_ADDR_STATUS = 4'h2;
    localparam logic [3:0] IPS_ADDR_LEVEL = 4'h3;
    localparam logic [3:0] IPS_ADDR_EDGE = 4'h4;
    localparam logic [3:0] IPS_ADDR_KEYCLR = 4'h5;
    localparam logic [3:0] IPS_ADDR_PRIO = 4'h6;
    // Pending bit positions
    localparam int IPS_BIT_LVL5 = 20;
    localparam int IPS_BIT_LVL6 = 19;
    localparam int IPS_BIT_LVL3 = 18;
    localparam int IPS_BIT_LVL2 = 17;
    localparam int IPS_BIT_LVL1 = 16;
    localparam int IPS_BIT_PWMB = 13;
    localparam int IPS_BIT_SERB = 12;
    localparam int IPS_BIT_KEY0 = 8;
    localparam int IPS_BIT_PWMA = 7;
    localparam int IPS_BIT_KPAD = 6;
    localparam int IPS_BIT_TMRB = 5;
    localparam int IPS_BIT_RTC = 4;
    localparam int IPS_BIT_WDOG = 3;
    localparam int IPS_BIT_SERA = 2;
    localparam int IPS_BIT_TMRA = 1;
    localparam int IPS_BIT_SPIB = 0;
    localparam int IPS_NUM_KEYS = 4;
    localparam int IPS_NUM_EXT = 4;
    // Implemented pending bits (20..16, 13..0); 15..14 reserved
    localparam logic [31:0] IPS_PEND_MASK = 32'h001F_3FFF;
    // Edge-type bits in the edge select register: ext 0..3, keys 4..7
    localparam int IPS_EDGE_KEY0 = 4;
    // Level control fields: 3 bits at 0, 4, 8, 12
    localparam int IPS_LVL_TMRB = 0;
    localparam int IPS_LVL_PWMB = 4;
    localparam int IPS_LVL_SERB = 8;
    localparam int IPS_LVL_SPIB = 12;
    localparam logic [15:0] IPS_LEVEL_RESET = 16'h6353;
    localparam logic [31:0] IPS_MASK_RESET = 32'hFFFF_FFFF;
    localparam logic [31:0] IPS_ZERO = 32'h0000_0000;
    localparam logic [2:0] IPS_LVL_NONE = 3'h0;
    localparam logic [2:0] IPS_LVL_ONE = 3'h1;
    localparam logic [2:0] IPS_LVL_TWO = 3'h2;
    localparam logic [2:0] IPS_LVL_THREE = 3'h3;
    localparam logic [2:0] IPS_LVL_FOUR = 3'h4;
    localparam logic [2:0] IPS_LVL_FIVE = 3'h5;
    localparam logic [2:0] IPS_LVL_SIX = 3'h6;
    localparam logic [2:0] IPS_LVL_BAD = 3'h7;
endpackage : ips_pkg
